//--- design/ppcr_regs.sv
// Serially written control registers with status byte.
// Assumes a serial front end presents whole bytes as a one-cycle strobe.
`timescale 1ns/1ps
module ppcr_regs
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic wr_strobe,
	input wire logic [7:0] wr_byte,
	input wire logic reset_monitor_out,
	input wire logic low_batt_raw,
	input wire logic tone_gate_in,
	input wire logic [2:0] chan_cmp_raw,
	output logic run_mode,
	output logic aux_reg_a_enable,
	output logic aux_reg_b_enable,
	output logic driver_a_on,
	output logic driver_b_on,
	output logic charge_low_on,
	output logic charge_high_on,
	output logic backup_on,
	output logic converter_enable,
	output logic [4:0] out_voltage_code,
	output logic [6:0] threshold_dac_code,
	output logic dac_power,
	output logic [7:0] status_readback
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic rsm_prev;
	always_ff @(posedge core_clk)
	begin
		sync_a <= {tone_gate_in, chan_cmp_raw, low_batt_raw};
		sync_b <= sync_a;
	end
	logic low_batt_n_s;
	logic tone_s;
	logic [2:0] chan_s;
	logic rsm_s1;
	logic rsm_s2;
	assign low_batt_n_s = sync_b[0];
	assign chan_s = sync_b[3:1];
	assign tone_s = sync_b[4];
	always_ff @(posedge core_clk)
	begin
		rsm_s1 <= reset_monitor_out;
		rsm_s2 <= rsm_s1;
		rsm_prev <= rsm_s2;
	end
	// Monitor fall and core reset share the same clear
	logic reg_clear;
	assign reg_clear = srst | (rsm_prev & ~rsm_s2);
	// ****************************************
	// Register writes
	// ****************************************
	logic [4:0] main_enables;
	logic [3:0] charge_backup_ctrl;
	logic [4:0] out_voltage_select;
	logic [6:0] dac_code;
	logic [6:0] cmp_code;
	logic [4:0] next_main_enables;
	logic [3:0] next_charge_backup_ctrl;
	logic [4:0] next_out_voltage_select;
	logic [6:0] next_dac_code;
	logic [6:0] next_cmp_code;
	logic [2:0] wr_addr;
	localparam int ADDR_TOP_POS_L = ppcr_pkg::ADDR_TOP_POS;
	localparam int ADDR_LSB_POS_L = ppcr_pkg::ADDR_LSB_POS;
	assign wr_addr = wr_byte[ADDR_TOP_POS_L:ADDR_LSB_POS_L];
	always_comb
	begin
		next_main_enables = main_enables;
		next_charge_backup_ctrl = charge_backup_ctrl;
		next_out_voltage_select = out_voltage_select;
		next_dac_code = dac_code;
		next_cmp_code = cmp_code;
		if (reg_clear)
		begin
			next_main_enables = ppcr_pkg::MAIN_ENABLES_RST;
			next_charge_backup_ctrl = ppcr_pkg::CHARGE_BACKUP_RST;
			next_out_voltage_select = ppcr_pkg::OUT_VOLTAGE_RST;
			next_dac_code = ppcr_pkg::DAC_CODE_RST;
			next_cmp_code = ppcr_pkg::DAC_CODE_RST;
		end
		else if (wr_strobe)
		begin
			// Code in force before this write drives the returned results
			next_cmp_code = dac_code;
			if (wr_byte[ADDR_TOP_POS_L])
				next_dac_code = wr_byte[6:0];
			else
			begin
				unique case (wr_addr)
					ppcr_pkg::ADDR_MAIN_ENABLES: next_main_enables = wr_byte[4:0];
					// Top data bit of this slot is unused and dropped
					ppcr_pkg::ADDR_CHARGE_BACKUP: next_charge_backup_ctrl = wr_byte[3:0];
					ppcr_pkg::ADDR_OUT_VOLTAGE: next_out_voltage_select = wr_byte[4:0];
					default: ;
				endcase
			end
		end
	end
	always_ff @(posedge core_clk)
	begin
		main_enables <= next_main_enables;
		charge_backup_ctrl <= next_charge_backup_ctrl;
		out_voltage_select <= next_out_voltage_select;
		dac_code <= next_dac_code;
		cmp_code <= next_cmp_code;
	end
	// ****************************************
	// Output decode
	// ****************************************
	logic backup_bit;
	logic auto_bit;
	logic backup_act;
	assign backup_bit = charge_backup_ctrl[ppcr_pkg::BACKUP_POS];
	assign auto_bit = charge_backup_ctrl[ppcr_pkg::AUTO_BACKUP_POS];
	// Detector output is active low: low means battery low
	assign backup_act = backup_bit | (auto_bit & ~low_batt_n_s);
	logic dac_on;
	assign dac_on = (cmp_code != ppcr_pkg::DAC_CODE_OFF);
	logic [7:0] next_status;
	always_comb
	begin
		// Stale results are masked while comparators are off
		next_status = {chan_s & {3{dac_on}}, ~low_batt_n_s, ppcr_pkg::STATUS_LOW_PAD};
	end
	always_ff @(posedge core_clk)
	begin
		run_mode <= main_enables[ppcr_pkg::RUN_POS];
		aux_reg_a_enable <= main_enables[ppcr_pkg::AUX_A_POS];
		aux_reg_b_enable <= main_enables[ppcr_pkg::AUX_B_POS];
		driver_a_on <= main_enables[ppcr_pkg::DRV_A_POS];
		driver_b_on <= main_enables[ppcr_pkg::DRV_B_POS] & tone_s;
		charge_low_on <= ~backup_act & charge_backup_ctrl[ppcr_pkg::CHG_LOW_POS];
		charge_high_on <= ~backup_act & charge_backup_ctrl[ppcr_pkg::CHG_HIGH_POS];
		backup_on <= backup_act;
		converter_enable <= ~backup_act;
		out_voltage_code <= out_voltage_select;
		threshold_dac_code <= dac_code;
		dac_power <= (dac_code != ppcr_pkg::DAC_CODE_OFF);
		status_readback <= next_status;
	end
	// ****************************************
	// Checks
	// ****************************************
	AST_RESET_COAST: assert property (@(posedge core_clk) srst |=> ##1 !run_mode && !backup_on)
		else $error("run or backup not cleared by reset");
	AST_VOLT_RESET: assert property (@(posedge core_clk) srst |=> ##1
		out_voltage_code == ppcr_pkg::OUT_VOLTAGE_RST)
		else $error("voltage code not at reset value");
	AST_BACKUP_WINS: assert property (@(posedge core_clk) disable iff (srst)
		backup_on |-> !charge_low_on && !charge_high_on && !converter_enable)
		else $error("charger or converter on during backup");
	AST_DRV_B_AND: assert property (@(posedge core_clk) disable iff (srst)
		driver_b_on |-> $past(tone_s))
		else $error("driver b on without tone gate");
	AST_DAC_LOAD: assert property (@(posedge core_clk) disable iff (srst)
		wr_strobe && wr_byte[7] && !reg_clear |=> ##1
		threshold_dac_code == $past(wr_byte[6:0], 2))
		else $error("dac code not loaded");
	AST_UNUSED_IGNORED: assert property (@(posedge core_clk) disable iff (srst)
		wr_strobe && wr_byte[7:5] == 3'h3 && !reg_clear |=> $stable(main_enables)
		&& $stable(charge_backup_ctrl) && $stable(out_voltage_select))
		else $error("reserved write changed state");
	AST_AUTO_OFF: assert property (@(posedge core_clk) disable iff (srst)
		!backup_bit && !auto_bit |=> !backup_on)
		else $error("backup without cause");
	AST_AUTO_ON: assert property (@(posedge core_clk) disable iff (srst)
		auto_bit && !low_batt_n_s |=> backup_on)
		else $error("auto backup did not engage");
	AST_PREV_CODE: assert property (@(posedge core_clk) disable iff (srst)
		wr_strobe && !reg_clear |=> cmp_code == $past(dac_code))
		else $error("compare code not previous");

	// ****************************************
	// Write and clear sequences
	// ****************************************
	// A write only lands when no clear shares its edge
	sequence seq_main_write;
		wr_strobe && !reg_clear && wr_addr == ppcr_pkg::ADDR_MAIN_ENABLES;
	endsequence

	sequence seq_charge_write;
		wr_strobe && !reg_clear && wr_addr == ppcr_pkg::ADDR_CHARGE_BACKUP;
	endsequence

	sequence seq_volt_write;
		wr_strobe && !reg_clear && wr_addr == ppcr_pkg::ADDR_OUT_VOLTAGE;
	endsequence

	// Synchronised monitor pin seen falling
	sequence seq_monitor_fall;
		rsm_prev && !rsm_s2;
	endsequence

	// Clear and write in one cycle: clear must win
	sequence seq_clear_write;
		wr_strobe && reg_clear;
	endsequence

	// ****************************************
	// Write path checks
	// ****************************************
	AST_RUN_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		seq_main_write |=> ##1 run_mode == $past(wr_byte[0], 2))
		else $error("run bit not taken from write");

	AST_AUX_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		seq_main_write |=> ##1 {aux_reg_b_enable, aux_reg_a_enable} == $past(wr_byte[2:1], 2))
		else $error("aux enables not taken from write");

	AST_DRV_A_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		seq_main_write |=> ##1 driver_a_on == $past(wr_byte[3], 2))
		else $error("driver a not taken from write");

	AST_VOLT_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		seq_volt_write |=> ##1 out_voltage_code == $past(wr_byte[4:0], 2))
		else $error("voltage code not taken from write");

	AST_CHG_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		seq_charge_write |=> charge_backup_ctrl == $past(wr_byte[3:0]))
		else $error("charge control not taken from write");

	// ****************************************
	// Output decode checks
	// ****************************************
	AST_CHG_FOLLOW: assert property (@(posedge core_clk) disable iff (srst)
		!backup_act |=> charge_low_on == $past(charge_backup_ctrl[ppcr_pkg::CHG_LOW_POS])
		&& charge_high_on == $past(charge_backup_ctrl[ppcr_pkg::CHG_HIGH_POS]))
		else $error("charger outputs do not follow bits");

	AST_BACKUP_BIT: assert property (@(posedge core_clk) disable iff (srst)
		backup_bit |=> backup_on)
		else $error("backup bit did not engage backup");

	AST_CONV_ON: assert property (@(posedge core_clk) disable iff (srst)
		!backup_on |-> converter_enable)
		else $error("converter off without backup");

	AST_DAC_POWER: assert property (@(posedge core_clk) disable iff (srst)
		dac_power == (threshold_dac_code != ppcr_pkg::DAC_CODE_OFF))
		else $error("dac power does not match code");

	AST_DAC_RESET: assert property (@(posedge core_clk) srst |=> ##1
		threshold_dac_code == ppcr_pkg::DAC_CODE_RST && !dac_power)
		else $error("dac code not cleared by reset");

	AST_STATUS_PAD: assert property (@(posedge core_clk) disable iff (srst)
		status_readback[3:0] == ppcr_pkg::STATUS_LOW_PAD)
		else $error("status low bits not padded");

	AST_LOWBATT_FLAG: assert property (@(posedge core_clk) disable iff (srst)
		status_readback[4] != $past(low_batt_n_s))
		else $error("low battery flag wrong");

	AST_CHAN_MASK: assert property (@(posedge core_clk) disable iff (srst)
		cmp_code == ppcr_pkg::DAC_CODE_OFF |=> status_readback[7:5] == 3'h0)
		else $error("channel results shown while comparators off");

	AST_DRV_B_OFF: assert property (@(posedge core_clk) disable iff (srst)
		!main_enables[ppcr_pkg::DRV_B_POS] |=> !driver_b_on)
		else $error("driver b on without enable");

	// ****************************************
	// Clear path checks
	// ****************************************
	AST_MONITOR_CLEAR: assert property (@(posedge core_clk)
		seq_monitor_fall |=> main_enables == ppcr_pkg::MAIN_ENABLES_RST
		&& out_voltage_select == ppcr_pkg::OUT_VOLTAGE_RST
		&& dac_code == ppcr_pkg::DAC_CODE_RST)
		else $error("monitor fall did not restore registers");

	AST_CLEAR_BEATS_WRITE: assert property (@(posedge core_clk)
		seq_clear_write |=> main_enables == ppcr_pkg::MAIN_ENABLES_RST
		&& charge_backup_ctrl == ppcr_pkg::CHARGE_BACKUP_RST)
		else $error("write survived a clear");
endmodule : ppcr_regs

//--- design/ppcr_pkg.sv
// Constants for the pager power control register bank.
// Assumes one 125 MHz core clock and a synchronous active-high reset.
// Functional notes
// - Run bit: 1 run, 0 coast, reset coast
// - Aux regulator enables on at 1, reset off
// - Driver enables on at 1, reset off
// - Charger bits enable; both set turns on both low and high
// - Backup bit enables backup, stops converter
// - Backup bit overrides charger and auto backup
// - Backup active disables converter and charging
// - Auto enable: low battery starts backup
// - Auto disabled: only backup bit starts backup
// - Voltage code five bits, reset code 01100
// - Hold seven-bit threshold DAC code
// - DAC code resets zero; zero powers off comparators
// - Status byte: chan c,b,a, low battery, zeros
// - Result 1 above threshold; flag low battery
// - Reset monitor fall restores power-on values
// - Byte: three address bits then five data
// - Top address bit loads seven-bit DAC code
// - Results compare against previous write's code
// - Driver b conducts on enable AND tone gate
package ppcr_pkg;
	// ****************************************
	// Addresses and field positions
	// ****************************************
	localparam logic [2:0] ADDR_MAIN_ENABLES = 3'h0;
	localparam logic [2:0] ADDR_CHARGE_BACKUP = 3'h1;
	localparam logic [2:0] ADDR_OUT_VOLTAGE = 3'h2;
	localparam int ADDR_TOP_POS = 7;
	localparam int ADDR_LSB_POS = 5;
	localparam int RUN_POS = 0;
	localparam int AUX_A_POS = 1;
	localparam int AUX_B_POS = 2;
	localparam int DRV_A_POS = 3;
	localparam int DRV_B_POS = 4;
	localparam int CHG_LOW_POS = 0;
	localparam int CHG_HIGH_POS = 1;
	localparam int BACKUP_POS = 2;
	localparam int AUTO_BACKUP_POS = 3;
	// ****************************************
	// Reset values, DAC off code and status pad
	// ****************************************
	localparam logic [4:0] MAIN_ENABLES_RST = 5'h00;
	localparam logic [3:0] CHARGE_BACKUP_RST = 4'h0;
	localparam logic [4:0] OUT_VOLTAGE_RST = 5'h0c;
	localparam logic [6:0] DAC_CODE_RST = 7'h00;
	localparam logic [6:0] DAC_CODE_OFF = 7'h00;
	localparam logic [3:0] STATUS_LOW_PAD = 4'h0;
endpackage : ppcr_pkg

//--- bench/ppcr_host.sv
// Host model that writes whole control bytes into the bank.
// Assumes the serial front end hands each byte over as a one-cycle strobe.
`timescale 1ns/1ps
module ppcr_host
(
	input wire logic core_clk,
	output logic wr_strobe,
	output logic [7:0] wr_byte
);
	initial
	begin
		wr_strobe = 1'b0;
		wr_byte = 8'h00;
	end
	task automatic send(input logic [7:0] b);
		@(posedge core_clk);
		wr_strobe <= 1'b1;
		wr_byte <= b;
		@(posedge core_clk);
		wr_strobe <= 1'b0;
		wr_byte <= ~b; // Stale byte must not look valid
	endtask : send
endmodule : ppcr_host

//--- bench/pager_power_control_registers_test.sv
// Self-checking bench for the power control register bank.
// Assumes the host model and a 125 MHz core clock.
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module pager_power_control_registers_test;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic reset_monitor_out = 1'b1;
	logic low_batt_raw = 1'b1;
	logic tone_gate_in = 1'b0;
	logic [2:0] chan_cmp_raw = 3'h0;
	logic wr_strobe;
	logic [7:0] wr_byte;
	logic [8:0] ctl;
	logic [4:0] vcode;
	logic [6:0] dcode;
	logic dpow;
	logic [7:0] stat;
	logic [4:0] m, v;
	logic [3:0] c;
	logic [6:0] d, pd;
	logic [29:0] exp_q[$];
	int failures = 0;
	int total_checks = 0;
	int seed = 76284;
	event seen;
	always #4 core_clk = ~core_clk;
	ppcr_host ppcr_host_i(.core_clk(core_clk), .wr_strobe(wr_strobe), .wr_byte(wr_byte));
	ppcr_regs ppcr_regs_i(.core_clk(core_clk), .srst(srst), .wr_strobe(wr_strobe),
		.wr_byte(wr_byte), .reset_monitor_out(reset_monitor_out),
		.low_batt_raw(low_batt_raw), .tone_gate_in(tone_gate_in),
		.chan_cmp_raw(chan_cmp_raw), .run_mode(ctl[8]), .aux_reg_a_enable(ctl[7]),
		.aux_reg_b_enable(ctl[6]), .driver_a_on(ctl[5]), .driver_b_on(ctl[4]),
		.charge_low_on(ctl[3]), .charge_high_on(ctl[2]), .backup_on(ctl[1]),
		.converter_enable(ctl[0]), .out_voltage_code(vcode),
		.threshold_dac_code(dcode), .dac_power(dpow), .status_readback(stat));
	task automatic clear_shadow();
		m = 5'h00;
		c = 4'h0;
		v = 5'h0c;
		d = 7'h00;
		pd = 7'h00;
	endtask : clear_shadow
	function automatic logic [29:0] expect_now();
		logic bk;
		bk = c[2] | (c[3] & ~low_batt_raw);
		return {m[0], m[1], m[2], m[3], m[4] & tone_gate_in, c[0] & ~bk, c[1] & ~bk, bk,
			~bk, v, d, d != 7'h00, chan_cmp_raw & {3{pd != 7'h00}}, ~low_batt_raw, 4'h0};
	endfunction : expect_now
	task automatic step(input int kind);
		logic [7:0] b;
		b = 8'($random(seed));
		@(posedge core_clk);
		low_batt_raw <= 1'($random(seed));
		tone_gate_in <= 1'($random(seed));
		chan_cmp_raw <= 3'($random(seed));
		if (kind == 0)
		begin
			ppcr_host_i.send(b);
			pd = d;
			if (b[7])
				d = b[6:0];
			else if (b[6:5] == 2'h0)
				m = b[4:0];
			else if (b[6:5] == 2'h1)
				c = b[3:0];
			else if (b[6:5] == 2'h2)
				v = b[4:0];
		end
		else if (kind == 1)
		begin
			reset_monitor_out <= 1'b0;
			repeat (6) @(posedge core_clk);
			reset_monitor_out <= 1'b1;
			clear_shadow();
		end
		else if (kind == 2)
		begin
			srst <= 1'b1;
			@(posedge core_clk);
			srst <= 1'b0;
			clear_shadow();
		end
		repeat (6) @(posedge core_clk);
		// Look after the edge has settled the outputs
		#1;
		exp_q.push_back(expect_now());
		->seen;
	endtask : step
	always @(seen)
	begin
		logic [29:0] e;
		e = exp_q.pop_front();
		`CHK({ctl, vcode, dcode, dpow}, e[29:8])
		`CHK(stat, e[7:0])
	end
	task automatic close_out();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	initial
	begin
		clear_shadow();
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		step(3);
		for (int i = 0; i < 300; i++)
			step((i % 60 == 59) ? 2 : ((($random(seed) & 7) == 0) ? 1 : 0));
		close_out();
	end
	initial
	begin
		#60000;
		failures++;
		close_out();
	end
endmodule : pager_power_control_registers_test
